// ==== hw/pgm_pkg.sv ====
package pgm_pkg;

  // rail count: two buck, two linear
  localparam int NUM_BUCK = 2;
  localparam int NUM_LIN  = 2;
  localparam int NUM_RAIL = NUM_BUCK + NUM_LIN;

  // register offsets
  localparam logic [3:0] ADDR_CONFIG_ONE = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_TWO = 4'h1;
  localparam logic [3:0] ADDR_FAULT      = 4'h2;
  localparam logic [3:0] ADDR_EVENTS     = 4'h3;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;

  // config one: [3:0] rail select, [7:4] window select, [8] polarity, [9] open drain
  localparam int CFG1_SEL_LSB = 0;
  localparam int CFG1_WIN_LSB = 4;
  localparam int CFG1_POL_BIT = 8;
  localparam int CFG1_OD_BIT  = 9;
  localparam logic [9:0] CFG1_RESET = 10'h00f;

  // config two: [0] thermal warn select, [1] mode, [2] fault holds output
  localparam int CFG2_TWARN_BIT = 0;
  localparam int CFG2_MODE_BIT  = 1;
  localparam int CFG2_GATE_BIT  = 2;
  localparam logic [2:0] CFG2_RESET = 3'h0;

  // events: [0] input overvoltage, [1] thermal shutdown
  localparam int EVT_OVP_BIT = 0;
  localparam int EVT_TSD_BIT = 1;

  // status: [0] pin valid flag, [1] gate timer running
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_HOLD_BIT  = 1;

  // gated hold window
  localparam int CLK_MHZ        = 100;
  localparam int GATE_HOLD_US   = 800;
  localparam int GATE_HOLD_CYC  = GATE_HOLD_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PGM_LOAD    = 2'b00,
    PGM_HOLD    = 2'b01,
    PGM_MONITOR = 2'b10
  } pgm_phase_t;

  // analog-side inputs, all synchronised before use
  typedef struct packed {
    logic [NUM_RAIL-1:0] rail_enabled;
    logic [NUM_RAIL-1:0] rail_under_ok;
    logic [NUM_RAIL-1:0] rail_over_ok;
    logic [NUM_RAIL-1:0] rail_ramping;
    logic                thermal_warning_state;
    logic                ovp_level;
    logic                tsd_level;
  } pgm_analog_t;

  // software bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pgm_bus_t;

endpackage : pgm_pkg

// ==== hw/pgm_monitor.sv ====
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Notes on behaviour
// - valid flag is one when pin shows good
// - polarity affects only the pin level
// - per-rail select bits include rails
// - disabled rails are ignored by the window check
// - optional thermal warning source
// - outside load and the gated hold, good only when every selected source valid
// - window bit adds overvoltage check
// - polarity and open-drain bits separate
// - mode bit, default from otp
// - gated mode starts asserted after load
// - gated hold 800 us after change
// - gated faults latch and suspend monitoring
// - continuous mode drops once rail enables
// - continuous mode tracks rails live
// - fault bits stay until written one
// - selected ramping rail forces output inactive in the monitor phase
// - without gating, continuous mode good returns when valid
// - gating keeps output low on pending faults
// - overvoltage event sticks while level high
// - shutdown event sticks while level high
module pgm_monitor #(
  parameter int HOLD_CYCLES = pgm_pkg::GATE_HOLD_CYC
)(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  // otp load done and mode strap
  input  wire logic                      otp_load_done,
  input  wire logic                      otp_mode_default,
  // analog monitors, asynchronous
  input  wire pgm_pkg::pgm_analog_t      analog_in,
  // event sources from protection logic, same clock, one-cycle pulses
  input  wire logic                      ovp_detect_pulse,
  input  wire logic                      tsd_detect_pulse,
  // register port
  input  wire pgm_pkg::pgm_bus_t         bus,
  output logic [15:0]                    rd_data,
  // pin
  output logic                           power_good_output,
  output logic                           power_good_oe,
  output logic                           pg_pin_valid_flag,
  output logic                           pg_change_event
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam int NR = pgm_pkg::NUM_RAIL;

  typedef struct packed {
    pgm_pkg::pgm_analog_t   s1;
    pgm_pkg::pgm_analog_t   s2;
    logic                   done_q;
    pgm_pkg::pgm_phase_t    phase;
    logic [CW-1:0]          hold_cnt;
    logic [NR-1:0]          en_q;
    logic [NR-1:0]          ramp_q;
    logic [9:0]             cfg1;
    logic [2:0]             cfg2;
    logic [NR-1:0]          rail_fault_latch_reg;
    logic [1:0]             events;
    logic                   pg_int;
    logic [15:0]            rdata;
    logic                   pin;
    logic                   oe;
    logic                   chg;
  } pgm_state_t;

  pgm_state_t st_r;
  pgm_state_t st_nxt;

  logic [NR-1:0] sel;
  logic [NR-1:0] win;
  logic [NR-1:0] rail_bad;
  logic          src_bad;
  logic          good;
  logic          restart;
  logic          wr_fault;
  logic          wr_evt;

  always_comb
  begin
    st_nxt   = st_r;
    sel      = st_r.cfg1[pgm_pkg::CFG1_SEL_LSB +: NR];
    win      = st_r.cfg1[pgm_pkg::CFG1_WIN_LSB +: NR];
    wr_fault = bus.wr && (bus.addr == pgm_pkg::ADDR_FAULT);
    wr_evt   = bus.wr && (bus.addr == pgm_pkg::ADDR_EVENTS);

    // two-stage synchroniser; only stage two is read
    st_nxt.s1 = analog_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.en_q   = st_r.s2.rail_enabled;
    st_nxt.ramp_q = st_r.s2.rail_ramping;
    st_nxt.done_q = otp_load_done;

    // rail is bad if selected, enabled, and out of its window
    rail_bad = sel & st_r.s2.rail_enabled
             & (~st_r.s2.rail_under_ok | (win & ~st_r.s2.rail_over_ok));
    src_bad  = (|rail_bad)
             | (st_r.cfg2[pgm_pkg::CFG2_TWARN_BIT] & st_r.s2.thermal_warning_state)
             | (|st_r.events);

    // rail enable or target change restarts gated window
    restart = |((st_r.s2.rail_enabled & ~st_r.en_q)
              | (st_r.s2.rail_ramping & ~st_r.ramp_q));

    // fault bits: set wins over clear
    st_nxt.rail_fault_latch_reg = (st_r.rail_fault_latch_reg
                                   & ~(wr_fault ? bus.wdata[NR-1:0] : '0))
                                  | rail_bad;
    // events stay while the level holds
    st_nxt.events[pgm_pkg::EVT_OVP_BIT] =
      ovp_detect_pulse | st_r.s2.ovp_level
      | (st_r.events[pgm_pkg::EVT_OVP_BIT]
         & ~(wr_evt & bus.wdata[pgm_pkg::EVT_OVP_BIT]));
    st_nxt.events[pgm_pkg::EVT_TSD_BIT] =
      tsd_detect_pulse | st_r.s2.tsd_level
      | (st_r.events[pgm_pkg::EVT_TSD_BIT]
         & ~(wr_evt & bus.wdata[pgm_pkg::EVT_TSD_BIT]));

    good = st_r.pg_int;
    case (st_r.phase)
      pgm_pkg::PGM_LOAD:
      begin
        good = 1'b1;
        if (st_r.done_q)
        begin
          // mode default latched after load, not under reset
          st_nxt.cfg2[pgm_pkg::CFG2_MODE_BIT] = otp_mode_default;
          st_nxt.phase = pgm_pkg::PGM_MONITOR;
          good = 1'b1;
        end
      end
      pgm_pkg::PGM_HOLD:
      begin
        // gated: output frozen while the window runs
        if (restart)
          st_nxt.hold_cnt = CW'(HOLD_CYCLES);
        else if (st_r.hold_cnt > CW'(1))
          st_nxt.hold_cnt = st_r.hold_cnt - CW'(1);
        else
          st_nxt.phase = pgm_pkg::PGM_MONITOR;
      end
      default:
      begin
        if (!st_r.cfg2[pgm_pkg::CFG2_MODE_BIT])
        begin
          if (restart)
          begin
            st_nxt.phase    = pgm_pkg::PGM_HOLD;
            st_nxt.hold_cnt = CW'(HOLD_CYCLES);
          end
          else if (src_bad | (|st_r.rail_fault_latch_reg))
            good = 1'b0;
          else
            good = 1'b1;
        end
        else
        begin
          // continuous: live, ramping forces low
          good = ~src_bad & ~(|(sel & st_r.s2.rail_ramping))
               & ~(st_r.s2.rail_enabled != '0 && !st_r.pg_int && src_bad);
          if (st_r.cfg2[pgm_pkg::CFG2_GATE_BIT] && (|st_r.rail_fault_latch_reg))
            good = 1'b0;
        end
      end
    endcase
    // ramping forces low in the monitor phase, gated mode too
    if (st_r.phase == pgm_pkg::PGM_MONITOR && (|(sel & st_r.s2.rail_ramping)))
      good = 1'b0;
    // continuous mode: rail turning on drops output at once
    if (st_r.cfg2[pgm_pkg::CFG2_MODE_BIT] && restart)
      good = 1'b0;
    // fault gating in gated mode too
    if (st_r.phase == pgm_pkg::PGM_MONITOR && st_r.cfg2[pgm_pkg::CFG2_GATE_BIT]
        && (|st_r.rail_fault_latch_reg))
      good = 1'b0;
    else if (st_r.phase == pgm_pkg::PGM_MONITOR && st_r.cfg2[pgm_pkg::CFG2_MODE_BIT]
             && !src_bad && !(|(sel & st_r.s2.rail_ramping)) && !restart)
      good = 1'b1;

    st_nxt.pg_int = good;
    st_nxt.chg    = st_r.pg_int & ~good;
    st_nxt.pin    = good ^ st_r.cfg1[pgm_pkg::CFG1_POL_BIT];
    // open drain: drive only the low level
    st_nxt.oe     = st_r.cfg1[pgm_pkg::CFG1_OD_BIT] ? ~st_nxt.pin : 1'b1;

    // register writes
    if (bus.wr && bus.addr == pgm_pkg::ADDR_CONFIG_ONE)
      st_nxt.cfg1 = bus.wdata[9:0];
    else if (bus.wr && bus.addr == pgm_pkg::ADDR_CONFIG_TWO)
      st_nxt.cfg2 = bus.wdata[2:0];

    // register reads, one cycle later
    st_nxt.rdata = 16'h0000;
    if (bus.rd)
    begin
      if (bus.addr == pgm_pkg::ADDR_CONFIG_ONE)
        st_nxt.rdata = {6'h00, st_r.cfg1};
      else if (bus.addr == pgm_pkg::ADDR_CONFIG_TWO)
        st_nxt.rdata = {13'h0000, st_r.cfg2};
      else if (bus.addr == pgm_pkg::ADDR_FAULT)
        st_nxt.rdata = {{(16-NR){1'b0}}, st_r.rail_fault_latch_reg};
      else if (bus.addr == pgm_pkg::ADDR_EVENTS)
        st_nxt.rdata = {14'h0000, st_r.events};
      else if (bus.addr == pgm_pkg::ADDR_STATUS)
        st_nxt.rdata = {14'h0000, st_r.phase == pgm_pkg::PGM_HOLD, st_r.pg_int};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_r        <= '0;
      st_r.phase  <= pgm_pkg::PGM_LOAD;
      st_r.cfg1   <= pgm_pkg::CFG1_RESET;
      st_r.cfg2   <= pgm_pkg::CFG2_RESET;
      st_r.pg_int <= 1'b1;
      st_r.pin    <= 1'b1;
      st_r.oe     <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_data           = st_r.rdata;
  assign power_good_output = st_r.pin;
  assign power_good_oe     = st_r.oe;
  assign pg_pin_valid_flag = st_r.pg_int;
  assign pg_change_event   = st_r.chg;

endmodule : pgm_monitor

// ==== test/pgm_monitor_props.sv ====
`timescale 1ns/100ps
module pgm_monitor_chk (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // register port
  input wire pgm_pkg::pgm_bus_t bus,
  input wire logic [15:0]       rd_data,
  // pin side
  input wire logic              power_good_output,
  input wire logic              power_good_oe,
  input wire logic              pg_pin_valid_flag,
  input wire logic              pg_change_event
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_RST_VAL: assert property ($rose(reset_n) |-> pg_pin_valid_flag && power_good_output
    && power_good_oe && !pg_change_event) else $error("pin not good after reset");
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rd_data == 16'h0)
    else $error("read data not zero outside read");
  AST_RD_UNMAPPED: assert property ($past(bus.rd) && $past(bus.addr) > 4'h4
    |-> rd_data == 16'h0) else $error("unmapped read not zero");
  AST_RD_STATUS: assert property ($past(bus.rd) && $past(bus.addr) == pgm_pkg::ADDR_STATUS
    |-> rd_data[0] == $past(pg_pin_valid_flag)) else $error("status flag wrong");
  AST_OE_OD: assert property (!power_good_oe |-> power_good_output)
    else $error("open drain released a low pin");
  AST_PIN_TRACK: assert property (!$past(bus.wr) && !$past(bus.wr, 2)
    && $changed(pg_pin_valid_flag) |-> $changed(power_good_output)) else $error("pin lost flag");
  AST_EVT_PULSE: assert property (pg_change_event |=> !pg_change_event)
    else $error("change event longer than one cycle");
  AST_EVT_ON_FALL: assert property ($fell(pg_pin_valid_flag) |-> ##[0:1] pg_change_event)
    else $error("no change event on drop");
  cover property ($fell(pg_pin_valid_flag));
  cover property ($past(bus.rd) && $past(bus.addr) == pgm_pkg::ADDR_STATUS);
  cover property (!power_good_oe);
endmodule : pgm_monitor_chk
bind pgm_monitor pgm_monitor_chk i_chk (.clk_sys, .reset_n, .bus, .rd_data,
  .power_good_output, .power_good_oe, .pg_pin_valid_flag, .pg_change_event);

// ==== test/pgm_proc_model.sv ====
`timescale 1ns/100ps
module pgm_proc_model (
  // pin from the monitor
  input wire logic power_good_output,
  input wire logic power_good_oe,
  // level seen at the reset input
  output logic     pin_level
);
  // board pull-up holds the line once the driver lets go
  assign pin_level = power_good_oe ? power_good_output : 1'b1;
endmodule : pgm_proc_model

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic                 clk_sys = 0;
  logic                 reset_n = 0;
  logic                 otp_load_done = 0;
  logic                 otp_mode_default = 1;
  pgm_pkg::pgm_analog_t analog_in = '0;
  logic                 ovp_detect_pulse = 0;
  logic                 tsd_detect_pulse = 0;
  pgm_pkg::pgm_bus_t    bus = '0;
  logic [15:0]          rd_data, lf = 16'h003a;
  logic [9:0]           c1 = 10'h00f;
  logic                 tw = 0;
  logic                 power_good_output, power_good_oe, pg_pin_valid_flag, pg_change_event;
  logic                 pin_level;
  logic [3:0]           flt = 4'h0;
  int                   fails = 0, tests_run = 0, cyc = 0, drops = 0, d0 = 0;
  always #5 clk_sys = ~clk_sys;
  // count active-to-inactive pulses seen on the change event
  always @(posedge clk_sys)
    if (pg_change_event === 1'b1)
      drops++;
  pgm_monitor #(.HOLD_CYCLES(20)) i_pgm_monitor (.clk_sys, .reset_n, .otp_load_done,
    .otp_mode_default, .analog_in, .ovp_detect_pulse, .tsd_detect_pulse, .bus, .rd_data,
    .power_good_output, .power_good_oe, .pg_pin_valid_flag, .pg_change_event);
  pgm_proc_model i_pgm_proc_model (.power_good_output, .power_good_oe, .pin_level);
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  // selected, enabled, non-ramping rails outside their window
  function automatic logic [3:0] bad();
    for (int i = 0; i < 4; i++)
      bad[i] = c1[i] && analog_in.rail_enabled[i] && !analog_in.rail_ramping[i]
        && !(analog_in.rail_under_ok[i] && (!c1[4+i] || analog_in.rail_over_ok[i]));
  endfunction : bad
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk(rd_data, e);
  endtask : rd
  // settle past sync and output stages, then compare
  task automatic pins(input logic g);
    repeat (6) @(posedge clk_sys);
    #1 chk(pg_pin_valid_flag, g);
    chk(power_good_output, g ^ c1[8]);
    chk(power_good_oe, c1[9] ? !(g ^ c1[8]) : 1'b1);
    chk(pin_level, g ^ c1[8]);
  endtask : pins
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1;
    rd(pgm_pkg::ADDR_CONFIG_ONE, 16'h000f);
    rd(pgm_pkg::ADDR_CONFIG_TWO, 16'h0000);
    rd(4'h9, 16'h0000);
    otp_load_done <= 1;
    analog_in <= {4'h0, 4'hf, 4'hf, 4'h0, 3'b000};
    pins(1);
    for (int k = 0; k < 40; k++)
    begin
      // all-ok between steps so no stray fault latches while config moves
      analog_in <= {4'h0, 4'hf, 4'hf, 4'h0, 3'b000};
      lf = nx(lf);
      c1 = lf[9:0];
      tw = lf[10];
      wr(pgm_pkg::ADDR_CONFIG_ONE, {6'h0, c1});
      wr(pgm_pkg::ADDR_CONFIG_TWO, {13'h0000, 2'b01, tw});
      lf = nx(lf);
      analog_in <= {lf[11:0], 4'h0, lf[12], 2'b00};
      // let the new levels land before the expectation is formed
      #1 flt = flt | bad();
      pins(bad() == 4'h0 && !(tw && analog_in.thermal_warning_state));
      chk(pg_pin_valid_flag, bad() == 4'h0 && !(tw && analog_in.thermal_warning_state));
    end
    c1 = 10'h00f;
    analog_in <= {4'h1, 4'hf, 4'hf, 4'h0, 3'b000};
    wr(pgm_pkg::ADDR_CONFIG_ONE, {6'h0, c1});
    wr(pgm_pkg::ADDR_CONFIG_TWO, 16'h0002);
    rd(pgm_pkg::ADDR_FAULT, {12'h0, flt});
    wr(pgm_pkg::ADDR_FAULT, 16'h000f);
    rd(pgm_pkg::ADDR_FAULT, 16'h0000);
    analog_in.rail_under_ok <= 4'he;
    pins(0);
    analog_in.rail_under_ok <= 4'hf;
    pins(1);
    wr(pgm_pkg::ADDR_CONFIG_TWO, 16'h0006);
    pins(0);
    wr(pgm_pkg::ADDR_FAULT, 16'h0001);
    pins(1);
    wr(pgm_pkg::ADDR_CONFIG_TWO, 16'h0002);
    for (int j = 0; j < 2; j++)
    begin
      {tsd_detect_pulse, ovp_detect_pulse} <= 2'b01 << j;
      @(posedge clk_sys);
      {tsd_detect_pulse, ovp_detect_pulse} <= 2'b00;
      pins(0);
      {analog_in.ovp_level, analog_in.tsd_level} <= j ? 2'b01 : 2'b10;
      repeat (4) @(posedge clk_sys);
      wr(pgm_pkg::ADDR_EVENTS, 16'h0003);
      rd(pgm_pkg::ADDR_EVENTS, 16'h0001 << j);
      {analog_in.ovp_level, analog_in.tsd_level} <= 2'b00;
      repeat (4) @(posedge clk_sys);
      wr(pgm_pkg::ADDR_EVENTS, 16'h0003);
      pins(1);
    end
    d0 = drops;
    analog_in.rail_ramping <= 4'h1;
    pins(0);
    chk(16'(drops - d0), 16'h0001);
    analog_in.rail_ramping <= 4'h0;
    pins(1);
    wr(pgm_pkg::ADDR_FAULT, 16'h000f);
    wr(pgm_pkg::ADDR_CONFIG_TWO, 16'h0000);
    analog_in.rail_under_ok <= 4'hd;
    analog_in.rail_enabled <= 4'h3;
    pins(1);
    rd(pgm_pkg::ADDR_STATUS, 16'h0003);
    repeat (30) @(posedge clk_sys);
    pins(0);
    analog_in.rail_under_ok <= 4'hf;
    pins(0);
    wr(pgm_pkg::ADDR_FAULT, 16'h0002);
    pins(1);
    rd(pgm_pkg::ADDR_STATUS, 16'h0001);
    final_report();
  end
endmodule : testbench
